// >>> logic/query_responder_map.svh
`ifndef QUERY_RESPONDER_MAP_SVH
`define QUERY_RESPONDER_MAP_SVH

// Query register addresses
`define QR_ADDR_STATUS     8'h32
`define QR_ADDR_INFO       8'h33
`define QR_ADDR_CAL_MEM    8'h34
`define QR_ADDR_USER_MEM   8'h35
`define QR_ADDR_SPI_CLOCK  8'h36

// Bytes written per query, address byte included
`define QR_LEN_STATUS      3'h2
`define QR_LEN_INFO        3'h2
`define QR_LEN_MEM         3'h4
`define QR_LEN_SPI_CLOCK   4'h8

// Response length in bytes
`define QR_RESP_BYTES      4'h8

// Information selector codes
`define QR_INFO_SERIAL     4'h0
`define QR_INFO_REVISION   4'h1
`define QR_INFO_DATES      4'h2
`define QR_INFO_INTERFACE  4'h3
`define QR_INFO_MFG_DATE   4'h4
`define QR_INFO_CAL_DATE   4'h5

// Memory read timing: wait cycles before each fetched byte is captured
`define QR_MEM_READ_LAT    2'h1

`endif

// >>> logic/query_responder_pkg.sv
package query_responder_pkg;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ARGS  = 5'b00010,
    ST_FETCH = 5'b00100,
    ST_LOAD  = 5'b01000,
    ST_SKIP  = 5'b10000
  } query_state_t;

  typedef logic [63:0] response_word_t;

endpackage

// >>> logic/memory_byte_store.sv
`timescale 1ns/1ns
`default_nettype none

// Nonvolatile memory image, one byte per entry, registered read data
module memory_byte_store (
  input  wire logic        clk_sys_in,  // System clock
  input  wire logic        clk_en_in,   // Clock enable
  input  wire logic [16:0] rd_addr_in,  // Bank bit plus 16-bit address
  output logic      [7:0]  rd_data_out, // Registered read data
  input  wire logic        wr_en_in,    // Preload write strobe
  input  wire logic [16:0] wr_addr_in,  // Preload address
  input  wire logic [7:0]  wr_data_in   // Preload data
);

  logic [7:0] mem_r [0:131071];

  always_ff @(posedge clk_sys_in) begin
    if (clk_en_in) begin
      if (wr_en_in) begin
        mem_r[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_r[rd_addr_in];
    end
  end

endmodule

`default_nettype wire

// >>> logic/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for a bus of asynchronous levels
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys_in, // System clock
  input  wire logic             nrst_in,    // Async reset, active low
  input  wire logic             clk_en_in,  // Clock enable
  input  wire logic [WIDTH-1:0] async_in,   // Asynchronous levels
  output logic      [WIDTH-1:0] sync_out    // Synchronised levels
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else if (clk_en_in) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

// >>> logic/query_register_responder.sv
`timescale 1ns/1ns
`default_nettype none
`include "query_responder_map.svh"

module query_register_responder
  import query_responder_pkg::*;
(
  input  wire logic        clk_sys_in,       // 20 MHz system clock
  input  wire logic        nrst_in,          // Async reset, active low
  input  wire logic        clk_en_in,        // Clock enable
  // Byte stream from host link
  input  wire logic        rx_valid_in,      // Host byte strobe
  input  wire logic        rx_first_in,      // Byte is register address
  input  wire logic [7:0]  rx_byte_in,       // Host byte
  input  wire logic        tx_take_in,       // Host takes a response byte
  output logic      [7:0]  tx_byte_out,      // Response byte
  output logic             tx_valid_out,     // Response byte available
  output logic             busy_out,         // Query in progress
  // Status sources, asynchronous pins
  input  wire logic [7:0]  loop_lock_in,     // Loop locks, status 7:0
  // Configuration state from same clock
  input  wire logic        sys_active_wr_in, // System-active config access
  input  wire logic [2:0]  ref_cfg_in,       // Ext lock, out en, out freq
  input  wire logic [2:0]  osc_powered_in,   // Synth power-up flags
  input  wire logic [1:0]  synth_loop_gain_in, // Synth loop gain
  input  wire logic [1:0]  first_osc_cfg_in, // Quick tuning, output route
  input  wire logic [3:0]  chain_cfg_in,     // Power, skips, ext input
  input  wire logic [3:0]  filter_cfg_in,    // Filter choices 32:29
  input  wire logic [3:0]  gain_cfg_in,      // Inv, amp, auto gain, preamp
  // Information content
  input  wire logic [31:0] serial_num_in,    // Serial number
  input  wire logic [7:0]  interface_id_in,  // Interface type byte
  input  wire logic [31:0] hw_rev_in,        // Hardware revision
  input  wire logic [31:0] fw_rev_in,        // Firmware revision
  input  wire logic [31:0] mfg_date_in,      // Manufacture date
  input  wire logic [31:0] cal_date_in,      // Calibration date
  // Memory preload port
  input  wire logic        mem_wr_in,        // Memory preload strobe
  input  wire logic [16:0] mem_wr_addr_in,   // Bank bit plus address
  input  wire logic [7:0]  mem_wr_data_in    // Preload byte
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  query_state_t   state_r;
  logic [7:0]     addr_r;
  logic [2:0]     arg_cnt_r;
  logic [23:0]    args_r;
  response_word_t resp_r;
  logic [3:0]     tx_cnt_r;
  logic [3:0]     fetch_cnt_r;
  logic [1:0]     wait_r;
  logic           accessed_r;
  logic [7:0]     lock_sync;
  logic [7:0]     mem_rd_data;
  logic [16:0]    mem_rd_addr;
  logic [2:0]     need_len;
  logic           known_addr;
  response_word_t status_word;
  response_word_t info_word;
  logic [15:0]    mem_base;
  logic           last_arg;
  logic           pop;

  // ---------------------------------------------------------------
  // Synchronised pins and memory
  // ---------------------------------------------------------------
  pin_sync #(.WIDTH(8)) u_lock_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .clk_en_in  (clk_en_in),
    .async_in   (loop_lock_in),
    .sync_out   (lock_sync)
  );

  assign mem_base    = args_r[15:0];
  assign mem_rd_addr = {addr_r == `QR_ADDR_USER_MEM,
                        16'(mem_base + {12'h000, fetch_cnt_r})};

  memory_byte_store u_mem (
    .clk_sys_in  (clk_sys_in),
    .clk_en_in   (clk_en_in),
    .rd_addr_in  (mem_rd_addr),
    .rd_data_out (mem_rd_data),
    .wr_en_in    (mem_wr_in),
    .wr_addr_in  (mem_wr_addr_in),
    .wr_data_in  (mem_wr_data_in)
  );

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  always_comb begin
    status_word        = '0;
    status_word[7:0]   = lock_sync;
    status_word[8]     = accessed_r;
    status_word[11:9]  = ref_cfg_in;
    status_word[14:12] = osc_powered_in;
    status_word[16:15] = synth_loop_gain_in;
    status_word[18:17] = first_osc_cfg_in;
    status_word[27:24] = chain_cfg_in;
    status_word[32:29] = filter_cfg_in;
    status_word[34:33] = gain_cfg_in[1:0];
    status_word[36:35] = gain_cfg_in[3:2];
  end

  // Sticky device-accessed flag
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      accessed_r <= 1'b0;
    end else if (clk_en_in && sys_active_wr_in) begin
      accessed_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Information word
  // ---------------------------------------------------------------
  always_comb begin
    info_word = '0;
    case (args_r[3:0])
      `QR_INFO_SERIAL:    info_word = {24'h0, interface_id_in, serial_num_in};
      `QR_INFO_REVISION:  info_word = {fw_rev_in, hw_rev_in};
      `QR_INFO_DATES:     info_word = {cal_date_in, mfg_date_in};
      `QR_INFO_INTERFACE: info_word = {56'h0, interface_id_in};
      `QR_INFO_MFG_DATE:  info_word = {32'h0, mfg_date_in};
      `QR_INFO_CAL_DATE:  info_word = {32'h0, cal_date_in};
      default:            info_word = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // Query decode
  // ---------------------------------------------------------------
  always_comb begin
    known_addr = 1'b1;
    case (addr_r)
      `QR_ADDR_STATUS:   need_len = `QR_LEN_STATUS;
      `QR_ADDR_INFO:     need_len = `QR_LEN_INFO;
      `QR_ADDR_CAL_MEM:  need_len = `QR_LEN_MEM;
      `QR_ADDR_USER_MEM: need_len = `QR_LEN_MEM;
      default: begin
        need_len   = 3'h1;
        known_addr = 1'b0;
      end
    endcase
  end

  assign last_arg = rx_valid_in && !rx_first_in
                    && (3'(arg_cnt_r + 3'h1) == need_len);
  assign pop      = tx_take_in && tx_valid_out;

  // ---------------------------------------------------------------
  // Query state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r     <= ST_IDLE;
      addr_r      <= 8'h00;
      arg_cnt_r   <= 3'h0;
      args_r      <= 24'h000000;
      fetch_cnt_r <= 4'h0;
      wait_r      <= 2'h0;
    end else if (clk_en_in) begin
      case (state_r)
        ST_IDLE, ST_ARGS: begin
          if (rx_valid_in && rx_first_in) begin
            addr_r    <= rx_byte_in;
            arg_cnt_r <= 3'h1;
            args_r    <= 24'h000000;
            state_r   <= (rx_byte_in == `QR_ADDR_SPI_CLOCK) ? ST_SKIP
                                                            : ST_ARGS;
          end else if (state_r == ST_ARGS && known_addr && rx_valid_in) begin
            args_r[8*(arg_cnt_r-3'h1) +: 8] <= rx_byte_in;
            arg_cnt_r <= 3'(arg_cnt_r + 3'h1);
            if (last_arg) begin
              state_r <= (addr_r == `QR_ADDR_CAL_MEM ||
                          addr_r == `QR_ADDR_USER_MEM) ? ST_FETCH : ST_LOAD;
            end
          end else if (state_r == ST_ARGS && known_addr
                       && addr_r == `QR_ADDR_STATUS
                       && arg_cnt_r == `QR_LEN_STATUS) begin
            state_r <= ST_LOAD;
          end
          fetch_cnt_r <= 4'h0;
          wait_r      <= 2'h0;
        end
        ST_FETCH: begin
          // Read latency of one cycle before each byte lands
          if (wait_r == `QR_MEM_READ_LAT) begin
            wait_r      <= 2'h0;
            fetch_cnt_r <= 4'(fetch_cnt_r + 4'h1);
            if (fetch_cnt_r == 4'(`QR_RESP_BYTES - 4'h1)) begin
              state_r <= ST_IDLE;
            end
          end else begin
            wait_r <= 2'(wait_r + 2'h1);
          end
        end
        ST_LOAD: begin
          state_r <= ST_IDLE;
        end
        ST_SKIP: begin
          // Output-buffer writes only clock data out; bytes ignored
          if (rx_valid_in && rx_first_in) begin
            addr_r  <= rx_byte_in;
            arg_cnt_r <= 3'h1;
            args_r  <= 24'h000000;
            state_r <= (rx_byte_in == `QR_ADDR_SPI_CLOCK) ? ST_SKIP
                                                          : ST_ARGS;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Response buffer and byte output
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resp_r   <= '0;
      tx_cnt_r <= 4'h0;
    end else if (clk_en_in) begin
      if (state_r == ST_LOAD) begin
        resp_r   <= (addr_r == `QR_ADDR_STATUS) ? status_word
                                                : info_word;
        tx_cnt_r <= `QR_RESP_BYTES;
      end else if (state_r == ST_FETCH && wait_r == `QR_MEM_READ_LAT) begin
        resp_r[8*fetch_cnt_r[2:0] +: 8] <= mem_rd_data;
        if (fetch_cnt_r == 4'(`QR_RESP_BYTES - 4'h1)) begin
          tx_cnt_r <= `QR_RESP_BYTES;
        end
      end else if (rx_valid_in && rx_first_in
                   && rx_byte_in != `QR_ADDR_SPI_CLOCK) begin
        tx_cnt_r <= 4'h0; // New query drops any unread response
      end else if (pop) begin
        resp_r   <= {resp_r[55:0], 8'h00};
        tx_cnt_r <= 4'(tx_cnt_r - 4'h1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_byte_out  <= 8'h00;
      tx_valid_out <= 1'b0;
      busy_out     <= 1'b0;
    end else if (clk_en_in) begin
      tx_byte_out  <= (pop && tx_cnt_r > 4'h1) ? resp_r[55:48]
                                               : resp_r[63:56];
      tx_valid_out <= (pop) ? (tx_cnt_r > 4'h1)
                            : (tx_cnt_r != 4'h0);
      busy_out     <= (state_r == ST_FETCH) || (state_r == ST_LOAD);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  sequence s_status_query;
    state_r == ST_LOAD && addr_r == `QR_ADDR_STATUS && clk_en_in;
  endsequence

  a_status_capture: assert property (
    s_status_query |=> resp_r == $past(status_word))
    else $error("status word not captured");

  a_reserved_zero: assert property (
    s_status_query |=> resp_r[63:37] == '0 && resp_r[28] == 1'b0
                       && resp_r[23:19] == '0)
    else $error("reserved status bits not zero");

  a_accessed_sticky: assert property (
    accessed_r |=> accessed_r)
    else $error("accessed flag cleared");

  a_accessed_set: assert property (
    sys_active_wr_in && clk_en_in |=> accessed_r)
    else $error("accessed flag not set");

  a_info_ignore_hi: assert property (
    state_r == ST_LOAD && addr_r == `QR_ADDR_INFO && clk_en_in
    && args_r[3:0] == `QR_INFO_INTERFACE
    |=> resp_r[63:8] == '0)
    else $error("interface info not isolated");

  a_fetch_bounded: assert property (
    state_r == ST_FETCH && $past(state_r) != ST_FETCH && clk_en_in
    |-> ##[1:40] state_r == ST_IDLE)
    else $error("memory fetch did not finish");

  a_msb_first: assert property (
    state_r == ST_LOAD && clk_en_in ##1 clk_en_in
    |=> tx_valid_out && tx_byte_out == $past(resp_r[63:56]))
    else $error("first byte is not most significant");

  a_skip_no_load: assert property (
    state_r == ST_SKIP |=> state_r != ST_LOAD)
    else $error("buffer clocking started a query");

  sequence s_frozen;
    !clk_en_in;
  endsequence

  a_freeze_hold: assert property (
    s_frozen |=> $stable(resp_r) && $stable(state_r)
                 && $stable(tx_valid_out) && $stable(tx_byte_out))
    else $error("state moved while clock enable low");

  a_eight_bytes: assert property (
    pop && tx_cnt_r == 4'h1 && clk_en_in |=> !tx_valid_out)
    else $error("response longer than eight bytes");

endmodule

`default_nettype wire

// >>> testbench/query_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------
// Host controller on the byte link
// ------------------------------------------------
module query_host_model (
  input  wire logic       clk_sys_in,   // System clock
  input  wire logic [7:0] tx_byte_in,   // Response byte
  input  wire logic       tx_valid_in,  // Response byte available
  output logic            rx_valid_out, // Host byte strobe
  output logic            rx_first_out, // Byte is register address
  output logic      [7:0] rx_byte_out,  // Host byte
  output logic            tx_take_out   // Response byte consumed
);
  initial begin
    rx_valid_out = 1'b0;
    rx_first_out = 1'b0;
    rx_byte_out  = 8'h00;
    tx_take_out  = 1'b0;
  end

  // Released byte lane shows the inverse of the last byte
  task automatic put(input logic first, input logic [7:0] b);
    @(negedge clk_sys_in);
    rx_valid_out = 1'b1;
    rx_first_out = first;
    rx_byte_out  = b;
    @(negedge clk_sys_in);
    rx_valid_out = 1'b0;
    rx_first_out = 1'b0;
    rx_byte_out  = ~b;
  endtask

  // Address first, then n-1 argument bytes, low byte first
  task automatic query(input logic [7:0] a, input int n,
                       input logic [23:0] args);
    put(1'b1, a);
    for (int i = 1; i < n; i++) begin
      put(1'b0, args[8*(i-1)+:8]);
    end
  endtask

  // Output-buffer register with seven zero data bytes
  task automatic spi_clock();
    put(1'b1, 8'h36);
    for (int i = 0; i < 7; i++) begin
      put(1'b0, 8'h00);
    end
  endtask

  // Takes n response bytes, first byte most significant
  task automatic get(input int n, output logic [63:0] w);
    int t;
    w = 64'h0;
    for (int i = 0; i < n; i++) begin
      t = 0;
      while (tx_valid_in !== 1'b1 && t < 200) begin
        @(negedge clk_sys_in);
        t++;
      end
      if (t == 200) begin
        w = 'x;
      end
      w = {w[55:0], tx_byte_in};
      tx_take_out = 1'b1;
      @(negedge clk_sys_in);
      tx_take_out = 1'b0;
      @(negedge clk_sys_in);
    end
  endtask
endmodule

`default_nettype wire

// >>> testbench/query_register_responder_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module query_register_responder_tb_top;
  import query_responder_pkg::*;

  logic           clk_sys_in;
  logic           nrst_in;
  logic           rx_v, rx_f, take, tx_v, busy, act_wr, m_wr, ce;
  logic [7:0]     rx_b, tx_b, lock, ifid, m_d;
  logic [2:0]     ref_c, osc_p;
  logic [1:0]     gain2, osc_c;
  logic [3:0]     chain, filt, gcfg;
  logic [31:0]    ser, hw, fw, mfg, cal;
  logic [16:0]    m_a;
  response_word_t w, a, b, e;
  int             errors;
  int             tests_run;
  int             hi;
  logic [7:0]     sel [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                              8'h06, 8'hf3};

  // ------------------------------------------------
  // Clock, device and host
  // ------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  query_register_responder uut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .clk_en_in(ce),
    .rx_valid_in(rx_v), .rx_first_in(rx_f), .rx_byte_in(rx_b),
    .tx_take_in(take), .tx_byte_out(tx_b), .tx_valid_out(tx_v),
    .busy_out(busy), .loop_lock_in(lock), .sys_active_wr_in(act_wr),
    .ref_cfg_in(ref_c), .osc_powered_in(osc_p),
    .synth_loop_gain_in(gain2), .first_osc_cfg_in(osc_c),
    .chain_cfg_in(chain), .filter_cfg_in(filt), .gain_cfg_in(gcfg),
    .serial_num_in(ser), .interface_id_in(ifid), .hw_rev_in(hw),
    .fw_rev_in(fw), .mfg_date_in(mfg), .cal_date_in(cal),
    .mem_wr_in(m_wr), .mem_wr_addr_in(m_a), .mem_wr_data_in(m_d));

  query_host_model host (
    .clk_sys_in(clk_sys_in), .tx_byte_in(tx_b), .tx_valid_in(tx_v),
    .rx_valid_out(rx_v), .rx_first_out(rx_f), .rx_byte_out(rx_b),
    .tx_take_out(take));

  // ------------------------------------------------
  // Expected words and checks
  // ------------------------------------------------
  function automatic response_word_t stat(input logic act);
    return {27'h0, gcfg, filt, 1'b0, chain, 5'h0, osc_c, gain2, osc_p,
            ref_c, act, lock};
  endfunction

  function automatic response_word_t info(input logic [3:0] c);
    case (c)
      4'h0: return {24'h0, ifid, ser};
      4'h1: return {fw, hw};
      4'h2: return {cal, mfg};
      4'h3: return {56'h0, ifid};
      4'h4: return {32'h0, mfg};
      4'h5: return {32'h0, cal};
      default: return 64'h0;
    endcase
  endfunction

  task automatic chk(input response_word_t got, input response_word_t exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic preload(input logic [16:0] ad, input logic [7:0] d);
    @(negedge clk_sys_in);
    m_wr = 1'b1;
    m_a  = ad;
    m_d  = d;
    @(negedge clk_sys_in);
    m_wr = 1'b0;
  endtask

  task automatic test_done();
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // Test sequence
  // ------------------------------------------------
  initial begin
    errors = 0;
    tests_run = 0;
    nrst_in = 1'b0;
    {act_wr, m_wr, m_a, m_d} = '0;
    ce = 1'b1;
    {lock, ref_c, osc_p, gain2, osc_c} = {8'ha5, 3'h5, 3'h6, 2'h2, 2'h1};
    {chain, filt, gcfg} = {4'h9, 4'hb, 4'h6};
    {ser, ifid, hw, fw} = {32'h1234_5678, 8'h0c, 32'h3f80_0000, 32'h4000_0000};
    {mfg, cal} = {32'h07e0_0c1f, 32'h07e1_0305};
    repeat (2) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      preload({1'b0, 16'hfffc + 16'(i)}, 8'h10 + 8'(i));
      preload({1'b1, 16'h0010 + 16'(i)}, 8'hc0 + 8'(i));
    end
    host.query(8'h32, 2, 24'h0);
    host.get(8, w);
    chk(w, stat(1'b0));
    chk({63'h0, tx_v}, 64'h0);
    @(negedge clk_sys_in);
    act_wr = 1'b1;
    @(negedge clk_sys_in);
    act_wr = 1'b0;
    {lock, ref_c, osc_p, gain2, osc_c} = {8'h5a, 3'h2, 3'h1, 2'h1, 2'h2};
    {chain, filt, gcfg} = {4'h6, 4'h4, 4'h9};
    repeat (4) @(negedge clk_sys_in);
    host.query(8'h32, 2, 24'h0);
    repeat (6) @(negedge clk_sys_in);
    e = stat(1'b1);
    ref_c = 3'h5;
    host.get(2, a);
    host.spi_clock();
    host.get(6, b);
    chk({a[15:0], b[47:0]}, e);
    foreach (sel[i]) begin
      host.query(8'h33, 2, {16'h0, sel[i]});
      host.get(8, w);
      chk(w, info(sel[i][3:0]));
    end
    host.query(8'h34, 4, 24'h00fffc);
    @(negedge clk_sys_in);
    chk({63'h0, busy}, 64'h1);
    host.get(8, w);
    chk(w, 64'h1716_1514_1312_1110);
    host.query(8'h35, 4, 24'h000010);
    host.get(8, w);
    chk(w, 64'hc7c6_c5c4_c3c2_c1c0);
    host.query(8'h31, 2, 24'h0);
    hi = 0;
    repeat (40) begin
      @(negedge clk_sys_in);
      hi += int'(tx_v === 1'b1);
    end
    chk(64'(hi), 64'h0);
    host.query(8'h32, 2, 24'h0);
    repeat (8) @(negedge clk_sys_in);
    host.query(8'h33, 2, 24'h000001);
    host.get(8, w);
    chk(w, info(4'h1));
    // Mid-run reset, then a response frozen by clock enable
    @(negedge clk_sys_in);
    nrst_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    chk({54'h0, tx_b, tx_v, busy}, 64'h0);
    repeat (2) @(negedge clk_sys_in);
    host.query(8'h32, 2, 24'h0);
    host.get(3, a);
    e = stat(1'b0);
    ce = 1'b0;
    host.put(1'b1, 8'h33);
    chk({55'h0, tx_v, tx_b}, {55'h0, 1'b1, e[39:32]});
    ce = 1'b1;
    host.get(5, b);
    chk({a[23:0], b[39:0]}, e);
    test_done();
  end

  initial begin
    #(50 * 20000);
    errors++;
    test_done();
  end
endmodule

`default_nettype wire
